// File: hdl/access_link_if.sv
interface access_link_if;
  logic req;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport device (input req, input we, input addr, input wdata, output rdata, output ack);
  modport debugger (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : access_link_if

// File: hdl/access_regs_debugger.sv
`include "access_regs_params.svh"
module access_regs_debugger
  import access_regs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // classic wishbone slave, addr is the register offset
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [7:0] dat_i,
  input wire logic sel_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  // link to the device
  access_link_if.debugger link
);

  ////////////////////////////////////////////////////////////////////////////
  dbg_state_t state_q;
  logic we_q;
  logic [3:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic ack_q;

  // forwards one bus cycle as one link access, then acks the bus
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= dbg_idle;
      we_q <= 1'b0;
      addr_q <= 4'h0;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      case (state_q)
        dbg_idle: begin
          if (cyc_i && stb_i) begin
            we_q <= we_i && sel_i; // no lane selected: nothing written
            addr_q <= adr_i;
            wdata_q <= dat_i;
            state_q <= dbg_req;
          end
        end
        dbg_req: begin
          if (link.ack) begin
            rdata_q <= link.rdata;
            ack_q <= 1'b1;
            state_q <= dbg_gap;
          end
        end
        dbg_gap: begin
          // wait for the bus to release before the next access
          if (!(cyc_i && stb_i) || ack_q) begin
            state_q <= (ack_q ? dbg_gap : dbg_idle);
          end
        end
        default: begin
          state_q <= dbg_idle;
        end
      endcase
    end
  end

  // clock select other than 4 MHz is left to software and brownout level
  // commit ordering after RAM load is software's duty
  assign link.req = (state_q == dbg_req);
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign dat_o = rdata_q;
  assign ack_o = ack_q;

endmodule : access_regs_debugger

// File: hdl/access_regs_device.sv
`include "access_regs_params.svh"
module access_regs_device
  import access_regs_pkg::*;
(
  // clock and reset; reset also falls when the link is disabled
  input wire logic clock,
  input wire logic rstn,
  // link side, the only path to these registers
  access_link_if.device link,
  // key decoder status
  input wire logic user_row_write_key,
  input wire logic nvm_program_key,
  input wire logic chip_erase_key,
  input wire logic nvm_program_done,
  input wire logic chip_erase_done,
  // system domain status
  input wire logic system_reset_seen,
  input wire logic system_asleep,
  input wire logic nvm_program_ready,
  input wire logic user_row_program_ready,
  input wire logic nvm_locked,
  input wire logic [2:0] memory_scan_result,
  // system domain controls
  output logic system_reset_request,
  output logic [1:0] link_clock_select,
  output logic system_clock_request,
  output logic user_row_commit
);

  ////////////////////////////////////////////////////////////////////////////
  logic wr;
  logic rd;
  logic reset_q;
  logic [1:0] clksel_q;
  logic system_clock_request_q;
  logic enabled_q;
  logic commit_q;
  logic nvm_key_q;
  logic erase_key_q;
  logic rst_seen_q;
  logic [7:0] rdata_q;
  logic ack_q;
  scan_state_t scan;

  // one access per request, answered in the next cycle
  assign wr = link.req && link.we && !ack_q;
  assign rd = link.req && !link.we && !ack_q;
  assign scan = scan_state_t'(memory_scan_result);

  // ack for one cycle, then drops even if req still high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= link.req && !ack_q;
    end
  end
  assign link.ack = ack_q;

  ////////////////////////////////////////////////////////////////////////////
  // held system reset; link logic is on rstn only, never on this output
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reset_q <= 1'b0;
    end else if (wr && link.addr == `RESET_TRIGGER_OFS) begin
      reset_q <= (link.wdata == `RESET_SIGNATURE);
    end
  end
  assign system_reset_request = reset_q;

  // clock select, reserved code accepted and passed on as written
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clksel_q <= `CLKSEL_RESET;
    end else if (wr && link.addr == `LINK_CLOCK_SELECT_OFS) begin
      clksel_q <= link.wdata[1:0];
    end
  end
  assign link_clock_select = clksel_q;

  // enable marker: low while the link is disabled, high from the first edge after
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enabled_q <= 1'b0;
    end else begin
      enabled_q <= 1'b1;
    end
  end

  // clock request: dropped while disabled, raised on the first edge after enable;
  // a link write in that same edge wins over the automatic set
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      system_clock_request_q <= 1'b0;
    end else if (wr && link.addr == `SYSTEM_CONTROL_OFS) begin
      system_clock_request_q <= link.wdata[`CTRL_SYSTEM_CLOCK_REQUEST_BIT];
    end else if (!enabled_q) begin
      system_clock_request_q <= 1'b1;
    end
  end
  assign system_clock_request = system_clock_request_q;

  // commit is a one-cycle start pulse, gated by the user-row key;
  // a pulse reads back as 0, so a later read-modify-write cannot restart it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= wr && link.addr == `SYSTEM_CONTROL_OFS && user_row_write_key
                  && link.wdata[`CTRL_COMMIT_BIT];
    end
  end
  assign user_row_commit = commit_q;

  ////////////////////////////////////////////////////////////////////////////
  // key flags: set by key, cleared when the sequence finishes; set wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      nvm_key_q <= 1'b0;
      erase_key_q <= 1'b0;
    end else begin
      if (nvm_program_key) begin
        nvm_key_q <= 1'b1;
      end else if (nvm_program_done) begin
        nvm_key_q <= 1'b0;
      end
      if (chip_erase_key) begin
        erase_key_q <= 1'b1;
      end else if (chip_erase_done) begin
        erase_key_q <= 1'b0;
      end
    end
  end

  // sticky reset flag, cleared by a read; a new reset in that cycle wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_seen_q <= 1'b0;
    end else if (system_reset_seen || reset_q) begin
      rst_seen_q <= 1'b1;
    end else if (rd && link.addr == `SYSTEM_STATE_OFS) begin
      rst_seen_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets and unused bits read zero
  // registered, so rdata stands from ack until the next read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= `REG_ZERO;
    end else if (rd) begin
      rdata_q <= `REG_ZERO;
      case (link.addr)
        `KEY_STATE_OFS: begin
          rdata_q[`KEY_USER_ROW_BIT] <= user_row_write_key;
          rdata_q[`KEY_NVM_PROG_BIT] <= nvm_key_q;
          rdata_q[`KEY_CHIP_ERASE_BIT] <= erase_key_q;
        end
        `RESET_TRIGGER_OFS: begin
          rdata_q[0] <= reset_q;
        end
        `LINK_CLOCK_SELECT_OFS: begin
          rdata_q[1:0] <= clksel_q;
        end
        `SYSTEM_CONTROL_OFS: begin
          rdata_q[`CTRL_SYSTEM_CLOCK_REQUEST_BIT] <= system_clock_request_q;
        end
        `SYSTEM_STATE_OFS: begin
          rdata_q[`STATE_RESET_BIT] <= rst_seen_q || reset_q;
          rdata_q[`STATE_ASLEEP_BIT] <= system_asleep;
          rdata_q[`STATE_NVM_READY_BIT] <= nvm_program_ready;
          rdata_q[`STATE_UROW_READY_BIT] <= user_row_program_ready;
          rdata_q[`STATE_LOCKED_BIT] <= nvm_locked;
        end
        `MEMORY_SCAN_STATE_OFS: begin
          rdata_q[2:0] <= scan;
        end
        default: begin
          rdata_q <= `REG_ZERO;
        end
      endcase
    end
  end
  assign link.rdata = rdata_q;

endmodule : access_regs_device

// File: hdl/access_regs_params.svh
`ifndef ACCESS_REGS_PARAMS_SVH
`define ACCESS_REGS_PARAMS_SVH
// register offsets on the access layer
`define KEY_STATE_OFS 4'h7
`define RESET_TRIGGER_OFS 4'h8
`define LINK_CLOCK_SELECT_OFS 4'h9
`define SYSTEM_CONTROL_OFS 4'ha
`define SYSTEM_STATE_OFS 4'hb
`define MEMORY_SCAN_STATE_OFS 4'hc
// field positions
`define KEY_USER_ROW_BIT 5
`define KEY_NVM_PROG_BIT 4
`define KEY_CHIP_ERASE_BIT 3
`define CTRL_COMMIT_BIT 1
`define CTRL_SYSTEM_CLOCK_REQUEST_BIT 0
`define STATE_RESET_BIT 5
`define STATE_ASLEEP_BIT 4
`define STATE_NVM_READY_BIT 3
`define STATE_UROW_READY_BIT 2
`define STATE_LOCKED_BIT 0
// values
`define RESET_SIGNATURE 8'h59
`define CLKSEL_RESET 2'h3
`define SYSTEM_STATE_RESET 8'h01
`define REG_ZERO 8'h00
`endif

// File: hdl/access_regs_pkg.sv
package access_regs_pkg;
  // link clock rates selected by the two-bit field
  typedef enum logic [1:0] {
    clk_reserved = 2'h0,
    clk_16mhz = 2'h1,
    clk_8mhz = 2'h2,
    clk_4mhz = 2'h3
  } link_clock_t;
  // memory scan result, one-hot, all zero when off
  typedef enum logic [2:0] {
    scan_off = 3'h0,
    scan_busy = 3'h1,
    scan_good = 3'h2,
    scan_bad = 3'h4
  } scan_state_t;
  // debugger side sequencer
  typedef enum logic [1:0] {
    dbg_idle,
    dbg_req,
    dbg_gap
  } dbg_state_t;
endpackage : access_regs_pkg

// File: testbench/access_link_sva.sv
`include "access_regs_params.svh"
module access_link_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // link signals
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic rd = ack && !we;
  logic held_q;
  ////////////////////////////////////////////////////////////////
  // tracks the last reset trigger write, so reads can be judged
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) held_q <= 1'b0;
    else if (ack && we && addr == `RESET_TRIGGER_OFS) held_q <= (wdata == `RESET_SIGNATURE);
  end
  ////////////////////////////////////////////////////////////////
  ack_after_req_a: assert property ($rose(req) |=> ack) else $error("link ack late");
  ack_pulse_a: assert property (ack |=> !ack) else $error("link ack too long");
  ack_held_a: assert property (ack |-> req && $past(req)) else $error("link ack without req");
  reset_hold_a: assert property (rd && addr == `RESET_TRIGGER_OFS |-> rdata == {7'h0, held_q})
    else $error("reset trigger read wrong");
  key_unused_a: assert property (rd && addr == `KEY_STATE_OFS |-> (rdata & 8'hc7) == 8'h00)
    else $error("key state unused bits set");
  clksel_unused_a: assert property (rd && addr == `LINK_CLOCK_SELECT_OFS |-> rdata[7:2] == 6'h0)
    else $error("clock select unused bits set");
  commit_reads_a: assert property (rd && addr == `SYSTEM_CONTROL_OFS |-> rdata[7:1] == 7'h0)
    else $error("system control unused bits set");
  state_unused_a: assert property (rd && addr == `SYSTEM_STATE_OFS |-> (rdata & 8'hc2) == 8'h00)
    else $error("system state unused bits set");
  scan_unused_a: assert property (rd && addr == `MEMORY_SCAN_STATE_OFS |-> rdata[7:3] == 5'h0)
    else $error("scan state unused bits set");
  unmapped_zero_a: assert property (rd && (addr < 4'h7 || addr > 4'hc) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : access_link_sva

// File: testbench/tb_debug_access_system_regs.sv
module tb_debug_access_system_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import access_regs_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, sel = 1'b0, we = 1'b0, ack;
  logic [3:0] adr = 4'h0;
  logic [7:0] dat_w = 8'h00, dat_r, q;
  logic uk = 1'b0, nk = 1'b0, ek = 1'b0, nd = 1'b0, ed = 1'b0, seen = 1'b0;
  logic asleep = 1'b0, nr = 1'b0, ur = 1'b0, locked = 1'b1;
  logic [2:0] scan = 3'h0;
  logic rst_req, clk_req, commit;
  logic [1:0] clk_sel;
  int miscompares = 0, tests_run = 0, commits = 0;
  access_link_if link_bus ();
  ////////////////////////////////////////////////////////////////
  access_regs_device u_access_regs_device (.clock(clock), .rstn(rstn), .link(link_bus),
    .user_row_write_key(uk), .nvm_program_key(nk), .chip_erase_key(ek),
    .nvm_program_done(nd), .chip_erase_done(ed), .system_reset_seen(seen),
    .system_asleep(asleep), .nvm_program_ready(nr), .user_row_program_ready(ur),
    .nvm_locked(locked), .memory_scan_result(scan), .system_reset_request(rst_req),
    .link_clock_select(clk_sel), .system_clock_request(clk_req), .user_row_commit(commit));
  // single byte lane, so sel is one bit driven with the request
  access_regs_debugger u_access_regs_debugger (.clock(clock), .rstn(rstn), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat_w), .sel_i(sel), .dat_o(dat_r),
    .ack_o(ack), .link(link_bus));
  access_link_sva u_access_link_sva (.clock(clock), .rstn(rstn), .req(link_bus.req),
    .we(link_bus.we), .addr(link_bus.addr), .wdata(link_bus.wdata),
    .rdata(link_bus.rdata), .ack(link_bus.ack));
  ////////////////////////////////////////////////////////////////
  // clock and commit pulse counter
  always #50 clock = ~clock;
  always @(posedge clock) if (commit === 1'b1) commits++;
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clock); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk(name, exp, q);
  endtask : rd
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd("key", 4'h7, 8'h00);
    rd("rst", 4'h8, 8'h00);
    rd("clksel", 4'h9, 8'h03);
    rd("sysctl", 4'ha, 8'h01);
    rd("state", 4'hb, 8'h01);
    rd("scan", 4'hc, 8'h00);
    rd("low", 4'h0, 8'h00);
    rd("high", 4'hf, 8'h00);
    chk("clk_req", 8'h01, {7'h0, clk_req});
    // brownout taken as at its highest level, so every rate may be chosen
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h9, 8'hfc | i[7:0]);
      rd("clksel", 4'h9, i[7:0]);
      chk("clk_sel", i[7:0], {6'h0, clk_sel});
    end
    // system reset held through the trigger, link keeps answering
    wb(1'b1, 4'h8, 8'h59);
    chk("rst_req", 8'h01, {7'h0, rst_req});
    rd("rst", 4'h8, 8'h01);
    rd("state", 4'hb, 8'h21);
    wb(1'b1, 4'h8, 8'h58);
    chk("rst_req", 8'h00, {7'h0, rst_req});
    rd("rst", 4'h8, 8'h00);
    wb(1'b0, 4'hb, 8'h00);
    rd("state", 4'hb, 8'h01);
    seen <= 1'b1;
    @(posedge clock);
    seen <= 1'b0;
    rd("state", 4'hb, 8'h21);
    rd("state", 4'hb, 8'h01);
    wb(1'b1, 4'ha, 8'h00);
    chk("clk_req", 8'h00, {7'h0, clk_req});
    wb(1'b1, 4'ha, 8'h03);
    chk("commits", 8'h00, commits[7:0]);
    chk("clk_req", 8'h01, {7'h0, clk_req});
    uk <= 1'b1;
    rd("key", 4'h7, 8'h20);
    // user-row data taken as already placed in RAM before the commit
    wb(1'b1, 4'ha, 8'h03);
    chk("commits", 8'h01, commits[7:0]);
    rd("sysctl", 4'ha, 8'h01);
    uk <= 1'b0;
    // NVM and erase key bits are set by their key and cleared by done, not by a write
    nk <= 1'b1;
    @(posedge clock);
    nk <= 1'b0;
    rd("key", 4'h7, 8'h10);
    nd <= 1'b1;
    @(posedge clock);
    nd <= 1'b0;
    rd("key", 4'h7, 8'h00);
    ek <= 1'b1;
    @(posedge clock);
    ek <= 1'b0;
    rd("key", 4'h7, 8'h08);
    ed <= 1'b1;
    @(posedge clock);
    ed <= 1'b0;
    rd("key", 4'h7, 8'h00);
    wb(1'b1, 4'h7, 8'hff);
    rd("key", 4'h7, 8'h00);
    asleep <= 1'b1;
    nr <= 1'b1;
    ur <= 1'b1;
    locked <= 1'b0;
    rd("state", 4'hb, 8'h1c);
    for (int i = 0; i < 4; i++) begin
      scan <= (i == 0) ? 3'h0 : 3'h1 << (i - 1);
      @(posedge clock);
      rd("scan", 4'hc, {5'h0, scan});
    end
    // link disabled mid-run: request and held reset drop, clock select to default
    wb(1'b1, 4'h9, 8'h01);
    wb(1'b1, 4'h8, 8'h59);
    wb(1'b1, 4'ha, 8'h01);
    rstn <= 1'b0;
    @(posedge clock);
    chk("clk_req_off", 8'h00, {7'h0, clk_req});
    chk("rst_req_off", 8'h00, {7'h0, rst_req});
    chk("clk_sel_off", 8'h03, {6'h0, clk_sel});
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd("sysctl", 4'ha, 8'h01);
    chk("clk_req_on", 8'h01, {7'h0, clk_req});
    rd("clksel", 4'h9, 8'h03);
    rd("rst", 4'h8, 8'h00);
    stop_test();
  end
  // watchdog sized well above the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test();
  end
endmodule : tb_debug_access_system_regs
